// ---- pkg/srcb_pkg.sv ----
// Constants and types for the stereo rate converter bank
//
// Summary of operation
// - Sixteen channels as eight stereo converters
// - Converter n owns channels 2n, 2n+1
// - Re-time input stream to target rate
// - Output is the buffered input sample, bit exact
// - Group delay depends on both rates
// - Lock needs signal, valid samples, rate
// - Mute bit silences converter any time
// - Per converter source and rate select
// - Ratio status per converter, consecutive addresses
`default_nettype none

package srcb_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_CONV   = 8;
	localparam int NUM_CHAN   = 16;
	localparam int NUM_SRC    = 4;
	localparam int SAMPLE_W   = 24;
	localparam int SEL_W      = 2;
	localparam int RATE_W     = 3;
	localparam int FIFO_DEPTH = 8;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [15:0] ADDR_LOCK   = 16'hF580;
	localparam logic [15:0] ADDR_MUTE   = 16'hF581;
	localparam logic [15:0] ADDR_RATIO0 = 16'hF582;
	localparam logic [7:0]  MUTE_RESET  = 8'h00;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CORE_HZ      = 10_000_000;
	localparam int RATE_32K     = 32_000;
	localparam int RATE_44K1    = 44_100;
	localparam int RATE_48K     = 48_000;
	localparam int RATE_88K2    = 88_200;
	localparam int RATE_96K     = 96_000;
	localparam int RATE_176K4   = 176_400;
	localparam int RATE_192K    = 192_000;
	// Code 0 is no target rate; periods round down
	localparam logic [15:0] RATE_PERIOD [8] = '{
		16'h0000,
		16'(CORE_HZ / RATE_32K),
		16'(CORE_HZ / RATE_44K1),
		16'(CORE_HZ / RATE_48K),
		16'(CORE_HZ / RATE_88K2),
		16'(CORE_HZ / RATE_96K),
		16'(CORE_HZ / RATE_176K4),
		16'(CORE_HZ / RATE_192K)
	};
	localparam logic [15:0] MIN_IN_PERIOD = 16'h0004;
	localparam logic [15:0] MAX_IN_PERIOD = 16'h04E2;
	localparam logic [15:0] PERIOD_TOL    = 16'h0002;
	localparam logic [3:0]  LOCK_COUNT    = 4'h4;
	localparam logic [3:0]  PRIME_WORDS   = 4'h2;

	typedef struct packed {
		logic [SAMPLE_W-1:0] left;
		logic [SAMPLE_W-1:0] right;
	} srcb_pair_t;

endpackage

`default_nettype wire

// ---- core/srcb_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides and flush
`default_nettype none

module srcb_fifo #(
	parameter int W     = 48,
	parameter int DEPTH = 8
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       flush,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [W-1:0]               in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [W-1:0]                    out_data,
	output logic [$clog2(DEPTH):0]          level
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0]  wr_q;
	logic [AW:0]  rd_q;
	logic         push;
	logic         pop;

	assign level     = wr_q - rd_q;
	assign in_ready  = (level != (AW+1)'(DEPTH));
	assign out_valid = (level != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rd_q[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (rst || flush)
			wr_q <= '0;
		else if (push)
			wr_q <= wr_q + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst || flush)
			rd_q <= '0;
		else if (pop)
			rd_q <= rd_q + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wr_q[AW-1:0]] <= in_data;
	end

endmodule

`default_nettype wire

// ---- core/srcb_bank.sv ----
// Eight stereo rate converters with lock, mute and ratio registers
`default_nettype none

module srcb_bank (
	input  wire logic                                              CORE_CLK,
	input  wire logic                                              RESET,
	input  wire logic [srcb_pkg::NUM_SRC-1:0]                      SRC_WCLK,
	input  wire srcb_pkg::srcb_pair_t [srcb_pkg::NUM_SRC-1:0]      SRC_DATA,
	input  wire logic [srcb_pkg::NUM_CONV-1:0][srcb_pkg::SEL_W-1:0]  SRC_SEL,
	input  wire logic [srcb_pkg::NUM_CONV-1:0][srcb_pkg::RATE_W-1:0] RATE_SEL,
	input  wire logic [15:0]                                       REG_ADDR,
	input  wire logic                                              REG_WR,
	input  wire logic [15:0]                                       REG_WDATA,
	output logic [15:0]                                            REG_RDATA,
	output logic [srcb_pkg::NUM_CONV-1:0]                          CONV_IN_READY,
	input  wire logic [srcb_pkg::NUM_CONV-1:0]                     OUT_READY,
	output logic [srcb_pkg::NUM_CONV-1:0]                          OUT_VALID,
	output srcb_pkg::srcb_pair_t [srcb_pkg::NUM_CONV-1:0]          OUT_DATA
);
	import srcb_pkg::*;

	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	// ****************************************
	// Input word clock synchronisers
	// ****************************************
	// Data is held by the source across its word clock edge, so it is
	// delayed by the same three stages and read on the detected edge.
	logic       [NUM_SRC-1:0] wclk_s1_q;
	logic       [NUM_SRC-1:0] wclk_s2_q;
	logic       [NUM_SRC-1:0] wclk_s3_q;
	logic       [NUM_SRC-1:0] wclk_lvl_q;
	logic       [NUM_SRC-1:0] src_rise;
	srcb_pair_t [NUM_SRC-1:0] dat_s1_q;
	srcb_pair_t [NUM_SRC-1:0] dat_s2_q;
	srcb_pair_t [NUM_SRC-1:0] dat_s3_q;

	always_ff @(posedge CORE_CLK)
	begin
		wclk_s1_q <= SRC_WCLK;
		wclk_s2_q <= wclk_s1_q;
		wclk_s3_q <= wclk_s2_q;
		dat_s1_q  <= SRC_DATA;
		dat_s2_q  <= dat_s1_q;
		dat_s3_q  <= dat_s2_q;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			wclk_lvl_q <= '0;
		else
			wclk_lvl_q <= (wclk_s2_q & wclk_s3_q) | (wclk_lvl_q & (wclk_s2_q | wclk_s3_q));
	end

	assign src_rise = (wclk_s2_q & wclk_s3_q) & ~wclk_lvl_q;

	// ****************************************
	// Mute register
	// ****************************************
	logic [NUM_CONV-1:0] mute_q;

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			mute_q <= MUTE_RESET;
		else if (REG_WR && REG_ADDR == ADDR_MUTE)
			mute_q <= REG_WDATA[NUM_CONV-1:0];
	end

	// ****************************************
	// Converters
	// ****************************************
	logic [NUM_CONV-1:0]        lock_w;
	logic [NUM_CONV-1:0][15:0]  per_q;

	// Converter c carries channel 2c as left and 2c+1 as right
	for (genvar c = 0; c < NUM_CONV; c++)
	begin : g_conv
		logic [SEL_W-1:0]  sel;
		logic [SEL_W-1:0]  sel_q;
		logic              rise;
		logic [15:0]       cnt_q;
		logic [15:0]       diff;
		logic              valid_edge;
		logic [3:0]        good_q;
		logic [15:0]       period;
		logic              rate_ok;
		logic [15:0]       tick_cnt_q;
		logic              tick;
		logic              pend_q;
		logic              take;
		logic              primed_q;
		logic              f_in_ready;
		logic              f_out_valid;
		srcb_pair_t        f_out_data;
		logic [LW-1:0]     level;

		assign sel        = SRC_SEL[c];
		assign rise       = src_rise[sel];
		assign diff       = (cnt_q > per_q[c]) ? cnt_q - per_q[c] : per_q[c] - cnt_q;
		assign valid_edge = rise && cnt_q >= MIN_IN_PERIOD && cnt_q <= MAX_IN_PERIOD
			&& diff <= PERIOD_TOL;
		assign period     = RATE_PERIOD[RATE_SEL[c]];
		assign rate_ok    = (period != 16'h0000);
		// Lost word clock drops lock without waiting for another edge
		assign lock_w[c]  = (good_q == LOCK_COUNT) && rate_ok
			&& cnt_q <= MAX_IN_PERIOD;
		assign tick       = rate_ok && tick_cnt_q == period - 16'h0001;
		assign take       = pend_q && OUT_READY[c];
		assign CONV_IN_READY[c] = f_in_ready;

		always_ff @(posedge CORE_CLK)
		begin
			if (RESET)
				sel_q <= '0;
			else
				sel_q <= sel;
		end

		// Input period measurement, also the ratio status
		always_ff @(posedge CORE_CLK)
		begin
			if (RESET)
				cnt_q <= 16'h0000;
			else if (rise)
				cnt_q <= 16'h0001;
			else if (cnt_q <= MAX_IN_PERIOD)
				cnt_q <= cnt_q + 16'h0001;
		end

		always_ff @(posedge CORE_CLK)
		begin
			if (RESET)
				per_q[c] <= 16'h0000;
			else if (rise)
				per_q[c] <= cnt_q;
		end

		always_ff @(posedge CORE_CLK)
		begin
			if (RESET || sel_q != sel || cnt_q > MAX_IN_PERIOD)
				good_q <= 4'h0;
			else if (rise && !valid_edge)
				good_q <= 4'h0;
			else if (valid_edge && good_q != LOCK_COUNT)
				good_q <= good_q + 4'h1;
		end

		// Output sample clock at the selected target rate
		always_ff @(posedge CORE_CLK)
		begin
			if (RESET || !rate_ok || tick)
				tick_cnt_q <= 16'h0000;
			else
				tick_cnt_q <= tick_cnt_q + 16'h0001;
		end

		// A new tick wins over the consumer taking the old one
		always_ff @(posedge CORE_CLK)
		begin
			if (RESET)
				pend_q <= 1'b0;
			else if (tick)
				pend_q <= 1'b1;
			else if (take)
				pend_q <= 1'b0;
		end

		// Output waits for a primed buffer, setting the rate-dependent delay
		always_ff @(posedge CORE_CLK)
		begin
			if (RESET || !lock_w[c])
				primed_q <= 1'b0;
			else if (level >= LW'(PRIME_WORDS))
				primed_q <= 1'b1;
		end

		// Zero-order hold: a starved buffer repeats the last sample
		always_ff @(posedge CORE_CLK)
		begin
			if (RESET)
				OUT_DATA[c] <= '0;
			else if (take && (mute_q[c] || !lock_w[c]))
				OUT_DATA[c] <= '0;
			else if (take && primed_q && f_out_valid)
				OUT_DATA[c] <= f_out_data;
		end

		always_ff @(posedge CORE_CLK)
		begin
			if (RESET)
				OUT_VALID[c] <= 1'b0;
			else
				OUT_VALID[c] <= take;
		end

		// Full buffer drops the incoming word; source sees CONV_IN_READY low
		srcb_fifo #(
			.W     ($bits(srcb_pair_t)),
			.DEPTH (FIFO_DEPTH)
		) u_fifo (
			.clk       (CORE_CLK),
			.rst       (RESET),
			.flush     (!lock_w[c]),
			.in_valid  (rise && lock_w[c]),
			.in_ready  (f_in_ready),
			.in_data   (dat_s3_q[sel]),
			.out_valid (f_out_valid),
			.out_ready (take && primed_q),
			.out_data  (f_out_data),
			.level     (level)
		);

		// ****************************************
		// Checks
		// ****************************************
		sequence s_mute_write;
			REG_WR && REG_ADDR == ADDR_MUTE && REG_WDATA[c];
		endsequence

		chk_mute_set: assert property (@(posedge CORE_CLK) disable iff (RESET)
			s_mute_write ##1 !(REG_WR && REG_ADDR == ADDR_MUTE) ##1 take
			|=> OUT_VALID[c] && OUT_DATA[c] == '0)
			else $error("muted converter output not zero");
		chk_unlock_zero: assert property (@(posedge CORE_CLK) disable iff (RESET)
			take && !lock_w[c] |=> OUT_DATA[c] == '0)
			else $error("unlocked converter output not zero");
		chk_lock_rate: assert property (@(posedge CORE_CLK) disable iff (RESET)
			lock_w[c] |-> RATE_SEL[c] != '0 && good_q == LOCK_COUNT)
			else $error("lock without rate or samples");
		chk_lost_unlock: assert property (@(posedge CORE_CLK) disable iff (RESET)
			cnt_q > MAX_IN_PERIOD |-> !lock_w[c] ##1 (good_q == 4'h0))
			else $error("lock kept after input loss");
		chk_unlock_flush: assert property (@(posedge CORE_CLK) disable iff (RESET)
			!lock_w[c] |=> level == '0 && !primed_q)
			else $error("buffer not flushed on unlock");
		chk_prime_hold: assert property (@(posedge CORE_CLK) disable iff (RESET)
			$rose(lock_w[c]) |-> !primed_q ##1 !primed_q)
			else $error("output started before priming");
		chk_ratio_read: assert property (@(posedge CORE_CLK) disable iff (RESET)
			REG_ADDR == ADDR_RATIO0 + 16'(c) |=> REG_RDATA == $past(per_q[c]))
			else $error("ratio status read wrong");
		chk_lock_read: assert property (@(posedge CORE_CLK) disable iff (RESET)
			REG_ADDR == ADDR_LOCK |=> REG_RDATA[c] == $past(lock_w[c]))
			else $error("lock flag read wrong");
		chk_tick_pace: assert property (@(posedge CORE_CLK) disable iff (RESET)
			tick && $stable(RATE_SEL[c]) |=> !tick [*8])
			else $error("output tick too fast");
	end

	// ****************************************
	// Register read
	// ****************************************
	logic [15:0] rdata_d;
	logic [15:0] ratio_idx;

	assign ratio_idx = REG_ADDR - ADDR_RATIO0;

	always_comb
	begin
		rdata_d = 16'h0000;
		if (REG_ADDR == ADDR_LOCK)
			rdata_d = {{(16-NUM_CONV){1'b0}}, lock_w};
		else if (REG_ADDR == ADDR_MUTE)
			rdata_d = {{(16-NUM_CONV){1'b0}}, mute_q};
		else if (REG_ADDR >= ADDR_RATIO0 && ratio_idx < 16'(NUM_CONV))
			rdata_d = per_q[ratio_idx[2:0]];
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			REG_RDATA <= 16'h0000;
		else
			REG_RDATA <= rdata_d;
	end

	chk_mute_write: assert property (@(posedge CORE_CLK) disable iff (RESET)
		REG_WR && REG_ADDR == ADDR_MUTE |=> mute_q == $past(REG_WDATA[NUM_CONV-1:0]))
		else $error("mute register write lost");

endmodule

`default_nettype wire

// ---- testbench/srcb_src_model.sv ----
// Word clock and sample source standing in for one audio input
`default_nettype none

module srcb_src_model #(
	parameter int PERIOD_NS = 800
) (
	input  wire logic                 run,
	input  wire srcb_pkg::srcb_pair_t pair,
	output logic                      wclk,
	output srcb_pkg::srcb_pair_t      data
);
	timeunit 1ns;
	timeprecision 1ns;
	import srcb_pkg::*;

	// ****************************************
	// Word clock and data
	// ****************************************
	// Data turns to garbage once the hold window is over, and while stopped
	always
	begin
		wclk = 1'b0;
		data = run ? pair : ~pair;
		#(PERIOD_NS / 4);
		wclk = run;
		#(PERIOD_NS / 2);
		wclk = 1'b0;
		#(PERIOD_NS / 8);
		data = ~pair;
		#(PERIOD_NS / 8);
	end

endmodule

`default_nettype wire

// ---- testbench/srcb_bank_test.sv ----
// Self-checking bench for the stereo rate converter bank
`default_nettype none

module srcb_bank_test;
	timeunit 1ns;
	timeprecision 1ns;
	import srcb_pkg::*;

	logic                            core_clk, reset, reg_wr, rd_due, rdy_due, watch;
	logic [NUM_SRC-1:0]              wclk, run;
	srcb_pair_t [NUM_SRC-1:0]        sdata, pair;
	logic [NUM_CONV-1:0][SEL_W-1:0]  sel;
	logic [NUM_CONV-1:0][RATE_W-1:0] rate;
	logic [15:0]                     addr, wdata, rdata, lk;
	logic [NUM_CONV-1:0]             in_rdy, ovalid, out_rdy;
	srcb_pair_t [NUM_CONV-1:0]       odata;
	srcb_pair_t                      n;
	logic [2:0]                      wconv;
	logic [31:0]                     rng;
	int                              err_count, comparisons;
	srcb_pair_t                      notes[$];

	// ****************************************
	// Clock, partners, design
	// ****************************************
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	for (genvar s = 0; s < NUM_SRC; s++)
	begin : g_src
		srcb_src_model m (.run(run[s]), .pair(pair[s]), .wclk(wclk[s]), .data(sdata[s]));
	end

	srcb_bank dut (
		.CORE_CLK(core_clk), .RESET(reset), .SRC_WCLK(wclk), .SRC_DATA(sdata),
		.SRC_SEL(sel), .RATE_SEL(rate), .REG_ADDR(addr), .REG_WR(reg_wr),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .CONV_IN_READY(in_rdy),
		.OUT_READY(out_rdy), .OUT_VALID(ovalid), .OUT_DATA(odata)
	);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	// Random back-pressure from the core, so takes wait on pending ticks
	always @(negedge core_clk)
		out_rdy = reset ? '1 : 8'(xs());

	task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// Unfiltered path, yet a distance of up to 2 is accepted
	task automatic cmp_out(input srcb_pair_t got, input srcb_pair_t exp);
		logic [SAMPLE_W-1:0] dl;
		logic [SAMPLE_W-1:0] dr;
		dl = got.left - exp.left;
		dr = got.right - exp.right;
		comparisons++;
		if (((dl + 24'h00_0002) <= 24'h00_0004 && (dr + 24'h00_0002) <= 24'h00_0004) !== 1'b1)
		begin
			err_count++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_wr_t(input logic [15:0] a, input logic [15:0] d);
		@(negedge core_clk);
		addr = a;
		wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask

	task automatic expect_reg(input logic [15:0] a, input logic [15:0] e);
		@(negedge core_clk);
		addr = a;
		notes.push_back(48'(e));
		@(negedge core_clk);
		rd_due = 1'b1;
		@(negedge core_clk);
		rd_due = 1'b0;
	endtask

	task automatic expect_rdy(input logic [15:0] e);
		@(negedge core_clk);
		notes.push_back(48'(e));
		rdy_due = 1'b1;
		@(negedge core_clk);
		rdy_due = 1'b0;
	endtask

	task automatic expect_out(input int c, input srcb_pair_t e);
		repeat (3) @(negedge core_clk);
		notes.push_back(e);
		wconv = 3'(c);
		watch = 1'b1;
		for (int i = 0; i < 2000 && notes.size() > 0; i++)
			@(negedge core_clk);
		watch = 1'b0;
		err_count += int'(notes.size() != 0);
		notes.delete();
	endtask

	always @(posedge core_clk)
	begin
		if (rd_due && notes.size() > 0)
		begin
			n = notes.pop_front();
			cmp_reg(rdata, n[15:0]);
		end
		if (rdy_due && notes.size() > 0)
		begin
			n = notes.pop_front();
			cmp_reg(16'(in_rdy) | lk, n[15:0]);
		end
		if (watch && ovalid[wconv] && notes.size() > 0)
			cmp_out(odata[wconv], notes.pop_front());
	end

	task automatic end_sim();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		#4_000_000;
		err_count++;
		end_sim();
	end

	initial
	begin
		rng = 32'h4c9e_c5af;
		{reg_wr, rd_due, rdy_due, watch, wconv, addr, wdata, run} = '0;
		lk = 16'h0000;
		err_count = 0;
		comparisons = 0;
		for (int c = 0; c < NUM_CONV; c++)
		begin
			sel[c] = 2'(xs());
			rate[c] = (c == 7) ? 3'h0 : 3'h1 + 3'(xs() % 7);
		end
		for (int s = 0; s < NUM_SRC; s++)
			pair[s] = {24'(xs()), 24'(xs())};
		reset = 1'b1;
		repeat (5) @(negedge core_clk);
		reset = 1'b0;
		expect_reg(ADDR_MUTE, 16'h0000);
		expect_reg(ADDR_LOCK, 16'h0000);
		$display("done: reset values");
		run = '1;
		repeat (200) @(negedge core_clk);
		expect_reg(ADDR_LOCK, 16'h007F);
		reg_wr_t(ADDR_LOCK, 16'h0000);
		expect_reg(ADDR_LOCK, 16'h007F);
		for (int c = 0; c < NUM_CONV; c++)
			expect_reg(ADDR_RATIO0 + 16'(c), 16'h0008);
		expect_reg(16'hF58A, 16'h0000);
		$display("done: lock and ratio");
		for (int c = 0; c < 7; c++)
			expect_out(c, pair[sel[c]]);
		$display("done: stereo outputs");
		reg_wr_t(ADDR_MUTE, 16'h0005);
		expect_reg(ADDR_MUTE, 16'h0005);
		expect_out(0, '0);
		expect_out(1, pair[sel[1]]);
		expect_out(2, '0);
		reg_wr_t(ADDR_MUTE, 16'h0000);
		$display("done: mute");
		run[sel[1]] = 1'b0;
		lk = 16'h007F;
		for (int c = 0; c < 7; c++)
			if (sel[c] == sel[1])
				lk[c] = 1'b0;
		repeat (1400) @(negedge core_clk);
		expect_reg(ADDR_LOCK, lk);
		expect_rdy(16'h00FF);
		expect_out(1, '0);
		$display("done: lock loss");
		run = '1;
		sel[1] = sel[1] + 2'h1;
		repeat (300) @(negedge core_clk);
		expect_reg(ADDR_LOCK, 16'h007F);
		expect_out(1, pair[sel[1]]);
		$display("done: source switch");
		end_sim();
	end

endmodule

`default_nettype wire
